// ==== rtl/tcc_channel_core.v ====
/*
  Counter core of one timer channel with an APB register slave.
  Holds count clock selection, input edge detection with optional noise filter,
  start sequencing and the five counting modes.
  Assumes one system clock, an APB master, and an asynchronous timer input pin.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"

module tcc_channel_core (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire timer_input_pin_i,
  output reg channel_interrupt_o,
  output reg start_trigger_o,
  output reg opclk_en_o,
  output reg channel_enabled_flag_o,
  output reg [15:0] counter_value_o
);

  // Software state
  reg [`TCC_CTRL_W-1:0] ctrl_r;
  reg [15:0] compare_capture_value_r;
  reg [15:0] presc_r;
  reg [15:0] presc_cnt_r;
  // Input path
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_s3_r;
  reg pin_lvl_r;
  reg nf_a_r;
  reg nf_b_r;
  reg samp_r;
  reg samp_d_r;
  // Channel state
  reg running_r;
  reg loaded_r;
  reg tclk_r;

  wire [2:0] mode = ctrl_r[`TCC_CTRL_MODE_HI:`TCC_CTRL_MODE_LO];
  wire count_source_select = ctrl_r[`TCC_CTRL_CCS];
  wire start_interrupt_enable = ctrl_r[`TCC_CTRL_SIE];
  wire nf_on = ctrl_r[`TCC_CTRL_NF];
  wire [1:0] edge_sel = ctrl_r[`TCC_CTRL_EDGE_HI:`TCC_CTRL_EDGE_LO];

  // APB decode; the slave never inserts wait states
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire hit_ctrl = paddr_i == `TCC_OFF_CTRL;
  wire hit_start = paddr_i == `TCC_OFF_START;
  wire hit_data = paddr_i == `TCC_OFF_DATA;
  wire hit_count = paddr_i == `TCC_OFF_COUNT;
  wire hit_presc = paddr_i == `TCC_OFF_PRESC;
  wire mapped = hit_ctrl | hit_start | hit_data | hit_count | hit_presc;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  wire channel_start_bit = wr & hit_start & pwdata_i[`TCC_START_BIT];
  wire channel_stop_bit = wr & hit_start & pwdata_i[`TCC_STOP_BIT];

  // Read data is latched in the setup phase so it comes from flops in the access phase
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      prdata_o <= `TCC_WORD_ZERO;
    else if (clk_en_i && psel_i && !penable_i)
    begin
      if (hit_ctrl)
        prdata_o <= {24'h00_0000, ctrl_r};
      else if (hit_start)
        prdata_o <= {30'h0000_0000, loaded_r | running_r, channel_enabled_flag_o};
      else if (hit_data)
        prdata_o <= {16'h0000, compare_capture_value_r};
      else if (hit_count)
        prdata_o <= {16'h0000, counter_value_o};
      else if (hit_presc)
        prdata_o <= {16'h0000, presc_r};
      else
        prdata_o <= `TCC_WORD_ZERO;
    end
  end

  // Edge detection on the sampled signal, valid only in an operation clock slot
  wire rise_det = opclk_en_o & samp_r & ~samp_d_r;
  wire fall_det = opclk_en_o & ~samp_r & samp_d_r;
  // The unused edge code falls back to rising edges
  wire edge_det = (edge_sel == `TCC_EDGE_FALL) ? fall_det :
    (edge_sel == `TCC_EDGE_BOTH) ? (rise_det | fall_det) : rise_det;

  // Count clock source
  wire tclk = count_source_select ? edge_det : opclk_en_o;

  // Capture edges use the registered path too, keeping capture aligned with counting
  reg edge_r;
  reg rise_r;
  reg fall_r;

  // Channel sequencer and counter. running_r marks that the start trigger has
  // been seen; loaded_r that the first count clock after it has loaded the counter.
  reg en_nxt;
  reg run_nxt;
  reg ld_nxt;
  reg irq_nxt;
  reg trg_nxt;
  reg [15:0] cnt_nxt;
  reg [15:0] data_nxt;
  always @*
  begin
    en_nxt = channel_enabled_flag_o;
    run_nxt = running_r;
    ld_nxt = loaded_r;
    irq_nxt = 1'b0;
    trg_nxt = 1'b0;
    cnt_nxt = counter_value_o;
    data_nxt = compare_capture_value_r;
    if (wr && hit_data)
      data_nxt = pwdata_i[15:0];
    if (channel_stop_bit)
    begin
      en_nxt = 1'b0;
      run_nxt = 1'b0;
      ld_nxt = 1'b0;
    end
    else if (channel_start_bit)
    begin
      case (mode)
        `TCC_MODE_EVENT:
        begin
          en_nxt = 1'b1;
          run_nxt = 1'b1;
          ld_nxt = 1'b1;
          cnt_nxt = compare_capture_value_r;
        end
        `TCC_MODE_ONECOUNT, `TCC_MODE_CAPONE:
        begin
          // A start write while already enabled is ignored
          if (!channel_enabled_flag_o)
          begin
            en_nxt = 1'b1;
            run_nxt = 1'b0;
            ld_nxt = 1'b0;
          end
        end
        default:
        begin
          en_nxt = 1'b1;
          run_nxt = 1'b0;
          ld_nxt = 1'b0;
        end
      endcase
    end
    else if (channel_enabled_flag_o)
    begin
      case (mode)
        `TCC_MODE_INTERVAL:
        begin
          if (tclk_r && !running_r)
          begin
            run_nxt = 1'b1;
            ld_nxt = 1'b1;
            trg_nxt = 1'b1;
            irq_nxt = start_interrupt_enable;
            cnt_nxt = compare_capture_value_r;
          end
          else if (tclk_r && counter_value_o == `TCC_CNT_ZERO)
          begin
            irq_nxt = 1'b1;
            cnt_nxt = compare_capture_value_r;
          end
          else if (tclk_r)
            cnt_nxt = counter_value_o - `TCC_CNT_ONE;
        end
        `TCC_MODE_EVENT:
        begin
          if (tclk_r && counter_value_o == `TCC_CNT_ZERO)
          begin
            irq_nxt = 1'b1;
            cnt_nxt = compare_capture_value_r;
          end
          else if (tclk_r)
            cnt_nxt = counter_value_o - `TCC_CNT_ONE;
        end
        `TCC_MODE_CAPTURE:
        begin
          if (tclk_r && !running_r)
          begin
            run_nxt = 1'b1;
            ld_nxt = 1'b1;
            trg_nxt = 1'b1;
            irq_nxt = start_interrupt_enable;
            cnt_nxt = `TCC_CNT_ZERO;
          end
          else if (running_r && edge_r)
          begin
            // First capture after start may measure no interval
            data_nxt = counter_value_o;
            irq_nxt = 1'b1;
            cnt_nxt = `TCC_CNT_ZERO;
          end
          else if (tclk_r && running_r)
            cnt_nxt = counter_value_o + `TCC_CNT_ONE;
        end
        `TCC_MODE_ONECOUNT:
        begin
          if (!running_r && edge_r)
          begin
            run_nxt = 1'b1;
            trg_nxt = 1'b1;
            irq_nxt = start_interrupt_enable;
          end
          else if (running_r && tclk_r && !loaded_r)
          begin
            ld_nxt = 1'b1;
            cnt_nxt = compare_capture_value_r;
          end
          else if (running_r && tclk_r && counter_value_o == `TCC_CNT_ZERO)
          begin
            irq_nxt = 1'b1;
            cnt_nxt = `TCC_CNT_FULL;
            run_nxt = 1'b0;
            ld_nxt = 1'b0;
          end
          else if (running_r && tclk_r)
            cnt_nxt = counter_value_o - `TCC_CNT_ONE;
        end
        `TCC_MODE_CAPONE:
        begin
          if (!running_r && rise_r)
          begin
            run_nxt = 1'b1;
            trg_nxt = 1'b1;
            irq_nxt = start_interrupt_enable;
          end
          else if (running_r && fall_r)
          begin
            data_nxt = counter_value_o;
            irq_nxt = 1'b1;
            run_nxt = 1'b0;
            ld_nxt = 1'b0;
          end
          else if (running_r && tclk_r && !loaded_r)
          begin
            ld_nxt = 1'b1;
            cnt_nxt = `TCC_CNT_ZERO;
          end
          else if (running_r && tclk_r)
            cnt_nxt = counter_value_o + `TCC_CNT_ONE;
        end
        default: run_nxt = running_r;
      endcase
    end
  end

  // All registered state but the read latch; one enable freezes it all.
  // Capture overrides a same-cycle software data write.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r <= `TCC_CTRL_RST;
      presc_r <= `TCC_PRESC_RST;
      presc_cnt_r <= `TCC_CNT_ZERO;
      opclk_en_o <= 1'b0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      pin_lvl_r <= 1'b0;
      nf_a_r <= 1'b0;
      nf_b_r <= 1'b0;
      samp_r <= 1'b0;
      samp_d_r <= 1'b0;
      tclk_r <= 1'b0;
      edge_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      channel_enabled_flag_o <= 1'b0;
      running_r <= 1'b0;
      loaded_r <= 1'b0;
      channel_interrupt_o <= 1'b0;
      start_trigger_o <= 1'b0;
      counter_value_o <= `TCC_CNT_RST;
      compare_capture_value_r <= `TCC_DATA_RST;
    end
    else if (clk_en_i)
    begin
      if (wr && hit_ctrl)
        ctrl_r <= pwdata_i[`TCC_CTRL_W-1:0];
      if (wr && hit_presc)
        presc_r <= pwdata_i[15:0];
      // Operation clock enable: one system clock pulse every presc_r+1 cycles
      if (presc_cnt_r >= presc_r)
        presc_cnt_r <= `TCC_CNT_ZERO;
      else
        presc_cnt_r <= presc_cnt_r + `TCC_CNT_ONE;
      opclk_en_o <= presc_cnt_r >= presc_r;
      // Pin synchroniser; the level moves only when the second and third stage agree
      pin_s1_r <= timer_input_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r)
        pin_lvl_r <= pin_s3_r;
      // Filter wants two agreeing extra samples, costing two operation clocks of latency
      if (opclk_en_o)
      begin
        nf_a_r <= pin_lvl_r;
        nf_b_r <= nf_a_r;
        samp_d_r <= samp_r;
        if (!nf_on)
          samp_r <= pin_lvl_r;
        else if (nf_a_r == nf_b_r)
          samp_r <= nf_b_r;
      end
      // Count clock and edges registered so the counter moves one system clock later
      tclk_r <= tclk & channel_enabled_flag_o;
      edge_r <= edge_det & channel_enabled_flag_o;
      rise_r <= rise_det & channel_enabled_flag_o;
      fall_r <= fall_det & channel_enabled_flag_o;
      channel_enabled_flag_o <= en_nxt;
      running_r <= run_nxt;
      loaded_r <= ld_nxt;
      channel_interrupt_o <= irq_nxt;
      start_trigger_o <= trg_nxt;
      counter_value_o <= cnt_nxt;
      compare_capture_value_r <= data_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tcc_consts.vh ====
/*
  Constants for the timer channel counter core: register offsets, field positions,
  mode codes, reset values and counter limits.
  Assumes it is included by the design file and the bench, by bare name.
*/
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Register byte offsets on the APB bus
`define TCC_OFF_CTRL 12'h000
`define TCC_OFF_START 12'h004
`define TCC_OFF_DATA 12'h008
`define TCC_OFF_COUNT 12'h00C
`define TCC_OFF_PRESC 12'h010

// Control register fields
`define TCC_CTRL_MODE_LO 0
`define TCC_CTRL_MODE_HI 2
`define TCC_CTRL_CCS 3
`define TCC_CTRL_SIE 4
`define TCC_CTRL_NF 5
`define TCC_CTRL_EDGE_LO 6
`define TCC_CTRL_EDGE_HI 7
`define TCC_CTRL_W 8
`define TCC_CTRL_RST 8'h00

// Start/stop register fields
`define TCC_START_BIT 0
`define TCC_STOP_BIT 1
`define TCC_STAT_EN 0
`define TCC_STAT_RUN 1

// Counting modes
`define TCC_MODE_INTERVAL 3'h0
`define TCC_MODE_EVENT 3'h1
`define TCC_MODE_CAPTURE 3'h2
`define TCC_MODE_ONECOUNT 3'h3
`define TCC_MODE_CAPONE 3'h4

// Valid edge selection
`define TCC_EDGE_FALL 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_BOTH 2'h2

// Counter values and resets
`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_FULL 16'hFFFF
`define TCC_CNT_ONE 16'h0001
`define TCC_DATA_RST 16'h0000
`define TCC_CNT_RST 16'hFFFF
`define TCC_PRESC_RST 16'h0000
`define TCC_WORD_ZERO 32'h0000_0000

`endif

// ==== tb/tcc_channel_core_assertions.sv ====
/* Port checker for the channel counter core.
   Assumes clk_en_i stays high, so every pulse lasts one clock. */
`timescale 1ns/10ps
`default_nettype none
module tcc_channel_core_assertions (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic channel_interrupt_o,
  input wire logic start_trigger_o,
  input wire logic channel_enabled_flag_o,
  input wire logic [15:0] counter_value_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  property p_ready;
    psel_i && penable_i |-> pready_o;
  endproperty
  property p_err_acc;
    pslverr_o |-> psel_i && penable_i;
  endproperty
  property p_err_map;
    psel_i && penable_i && paddr_i == 12'h014 |-> pslverr_o;
  endproperty
  property p_irq_one;
    channel_interrupt_o |=> !channel_interrupt_o;
  endproperty
  property p_trig_one;
    start_trigger_o |=> !start_trigger_o;
  endproperty
  // Stopped channel keeps its count until a start re-enables it
  property p_frozen;
    !channel_enabled_flag_o |=> channel_enabled_flag_o || $stable(counter_value_o);
  endproperty
  property p_irq_en;
    channel_interrupt_o |-> channel_enabled_flag_o || $past(channel_enabled_flag_o);
  endproperty
  property p_trig_en;
    start_trigger_o |-> channel_enabled_flag_o || $past(channel_enabled_flag_o);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_err_acc: assert property (p_err_acc) else $error("error outside access");
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  a_irq_one: assert property (p_irq_one) else $error("interrupt too long");
  a_trig_one: assert property (p_trig_one) else $error("trigger too long");
  a_frozen: assert property (p_frozen) else $error("counter moved while stopped");
  a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
  a_trig_en: assert property (p_trig_en) else $error("trigger while disabled");
  c_irq: cover property (channel_interrupt_o);
  c_trig: cover property (start_trigger_o);
  c_err: cover property (pslverr_o);
endmodule
bind tcc_channel_core tcc_channel_core_assertions u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .channel_interrupt_o(channel_interrupt_o), .start_trigger_o(start_trigger_o),
  .channel_enabled_flag_o(channel_enabled_flag_o), .counter_value_o(counter_value_o));
`default_nettype wire

// ==== tb/tcc_pin_model.sv ====
/* Far-side model: square wave on the timer input pin.
   Assumes run_i and half_i change just after bench clock edges. */
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  output logic pin_o
);
  logic [7:0] cnt_r;
  // Pin idles low between bursts; first rise one edge after run goes high
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      cnt_r <= 8'h00;
      pin_o <= 1'b0;
    end
    else if (cnt_r == 8'h00)
    begin
      cnt_r <= half_i - 8'h01;
      pin_o <= ~pin_o;
    end
    else
      cnt_r <= cnt_r - 8'h01;
  end
endmodule
`default_nettype wire

// ==== tb/test_timer_channel_counter_core.sv ====
/* Bench: register table over APB, then the five counting modes.
   Assumes the pin model drives the timer input and clk_en_i is held high. */
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module test_timer_channel_counter_core;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [32:0] e;} tcc_row_t;
  logic clk_sys_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, run = 0;
  logic pin, rdy, err, irq, trg, ena, se, opk;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prd, rd, v1;
  logic [15:0] cnt, c;
  logic [7:0] half = 8'h28;
  int n_errors = 0, n_tests = 0, d0, d1, g;
  // Expected word carries the error flag above the read data
  tcc_row_t rows [11] = '{
    '{1'b0, `TCC_OFF_CTRL, 32'h0000_0000, 33'h0_0000_0000},
    '{1'b0, `TCC_OFF_START, 32'h0000_0000, 33'h0_0000_0000},
    '{1'b0, `TCC_OFF_DATA, 32'h0000_0000, 33'h0_0000_0000},
    '{1'b0, `TCC_OFF_COUNT, 32'h0000_0000, 33'h0_0000_FFFF},
    '{1'b0, `TCC_OFF_PRESC, 32'h0000_0000, 33'h0_0000_0000},
    '{1'b0, 12'h014, 32'h0000_0000, 33'h1_0000_0000},
    '{1'b1, 12'h014, 32'h0000_1234, 33'h1_0000_0000},
    '{1'b1, `TCC_OFF_DATA, 32'h0000_1234, 33'h0_0000_0000},
    '{1'b0, `TCC_OFF_DATA, 32'h0000_0000, 33'h0_0000_1234},
    '{1'b1, `TCC_OFF_COUNT, 32'h0000_5555, 33'h0_0000_0000},
    '{1'b0, `TCC_OFF_COUNT, 32'h0000_0000, 33'h0_0000_FFFF}};
  tcc_channel_core u_tcc_channel_core (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .timer_input_pin_i(pin), .channel_interrupt_o(irq),
    .start_trigger_o(trg), .opclk_en_o(opk), .channel_enabled_flag_o(ena), .counter_value_o(cnt));
  tcc_pin_model u_tcc_pin_model (.clk_i(clk_sys_i), .run_i(run), .half_i(half), .pin_o(pin));
  initial
    forever #4 clk_sys_i = ~clk_sys_i;
  task chk(input logic [32:0] s, input logic [32:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Request held until ready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_sys_i);
    while (rdy !== 1'b1);
    rd = prd;
    se = err;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Always passes one edge first, so a pulse already seen is skipped
  task automatic wt(ref logic s, output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (s !== 1'b1 && n < 3000);
    if (n >= 3000)
      n_errors++;
  endtask
  // One rising pin edge; returns edges until the counter moves
  task pulse(output int d);
    run <= 1'b1;
    @(posedge pin);
    c = cnt;
    d = 0;
    do
    begin
      @(posedge clk_sys_i);
      d++;
    end
    while (cnt === c && d < 50);
    run <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #160000;
    n_errors++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({se, rd & {32{~rows[i].w}}}, rows[i].e);
    end
    // Interval timer, start interrupt on, period of four count clocks
    apb(1'b1, `TCC_OFF_DATA, 32'h0000_0003);
    apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0010);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0001);
    wt(trg, g);
    chk(33'(irq), 33'h0_0000_0001);
    wt(irq, g);
    chk(33'(g), 33'h0_0000_0004);
    wt(irq, g);
    chk(33'(g), 33'h0_0000_0004);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0002);
    @(posedge clk_sys_i);
    chk(33'(ena), 33'h0_0000_0000);
    // Event counter on rising pin edges, then with the filter
    apb(1'b1, `TCC_OFF_DATA, 32'h0000_0005);
    apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0049);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0001);
    @(posedge clk_sys_i);
    chk(33'(cnt), 33'h0_0000_0005);
    pulse(d0);
    pulse(d0);
    chk(33'(cnt), 33'h0_0000_0003);
    chk(33'(d0), 33'h0_0000_0008);
    apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0069);
    pulse(d1);
    chk(33'(d1 - d0), 33'h0_0000_0002);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0002);
    // Capture on both edges: second capture measures a ten cycle half period
    half <= 8'h0A;
    apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0082);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0001);
    run <= 1'b1;
    wt(trg, g);
    chk(33'(cnt), 33'h0_0000_0000);
    wt(irq, g);
    wt(irq, g);
    run <= 1'b0;
    apb(1'b0, `TCC_OFF_DATA, 32'h0000_0000);
    chk({se, rd}, 33'h0_0000_0009);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0002);
    // One-count on falling edges: holds until trigger, ends at all ones
    apb(1'b1, `TCC_OFF_DATA, 32'h0000_0004);
    apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0003);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0001);
    c = cnt;
    repeat (10) @(posedge clk_sys_i);
    chk(33'(cnt), 33'(c));
    half <= 8'h28;
    run <= 1'b1;
    wt(trg, g);
    wt(irq, g);
    repeat (3) @(posedge clk_sys_i);
    chk({ena, cnt}, 33'h0_0001_FFFF);
    run <= 1'b0;
    apb(1'b1, `TCC_OFF_START, 32'h0000_0002);
    // High width 12 then 20 cycles, captures differ by eight
    half <= 8'h0C;
    apb(1'b1, `TCC_OFF_CTRL, 32'h0000_0044);
    apb(1'b1, `TCC_OFF_START, 32'h0000_0001);
    run <= 1'b1;
    wt(irq, g);
    run <= 1'b0;
    apb(1'b0, `TCC_OFF_DATA, 32'h0000_0000);
    v1 = rd;
    half <= 8'h14;
    run <= 1'b1;
    wt(irq, g);
    run <= 1'b0;
    apb(1'b0, `TCC_OFF_DATA, 32'h0000_0000);
    chk(33'(rd - v1), 33'h0_0000_0008);
    // A divider of one makes the operation clock enable a pulse every other cycle
    apb(1'b1, `TCC_OFF_PRESC, 32'h0000_0001);
    repeat (2) @(posedge clk_sys_i);
    v1[0] = opk;
    @(posedge clk_sys_i);
    chk(33'(opk ^ v1[0]), 33'h0_0000_0001);
    test_done;
  end
endmodule
`default_nettype wire
